// ===== event_status_enable_logic.sv
// Purpose: event flags, enable mask, summary bit and service request
// Assumes: commands arrive as decoded one-cycle strobes
// Notes: reply characters leave through a ready/valid byte port
`timescale 1ns/10ps
`include "event_status_map.svh"

module event_status_enable_logic (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input event_status_pkg::cmd_t cmd,
    input wire logic acq_complete,
    input wire logic stop_event,
    input wire logic query_error,
    input wire logic param_conflict,
    input wire logic invalid_option_error,
    input wire logic invalid_command_error,
    input wire logic buffer_threshold,
    input wire logic srq_event_enable,
    input wire logic reply_ready,
    output logic [7:0] event_enable_mask,
    output logic [7:0] event_status_flags,
    output logic event_summary_bit,
    output logic [7:0] serial_poll_status,
    output logic service_request,
    output logic [7:0] status_data,
    output logic status_valid,
    output logic reply_valid,
    output logic [7:0] reply_char,
    output logic reply_busy
);

    logic [7:0] pend, next_pend;
    logic pend_clr, next_pend_clr;
    logic [7:0] next_mask, next_flags, sets, next_status_data;
    logic next_summary, next_srq, next_status_valid, arg_bad;

    // ============================================================
    // event sources, sampled as pulses or levels
    always_comb begin
        sets = 8'h00;
        sets[`FLAG_ACQ_DONE] = acq_complete; // [RULE_07]
        sets[`FLAG_STOP_EVENT] = stop_event; // [RULE_08]
        sets[`FLAG_QUERY_ERR] = query_error; // [RULE_09]
        sets[`FLAG_CONFLICT_ERR] = param_conflict; // [RULE_10]
        // out-of-range argument counts as an invalid option
        sets[`FLAG_EXEC_ERR] = invalid_option_error | arg_bad; // [RULE_11]
        sets[`FLAG_CMD_ERR] = invalid_command_error; // [RULE_12]
        sets[`FLAG_BUF_THRESH] = buffer_threshold; // [RULE_13]
        sets[`FLAG_POWER_ON] = cmd.power_on_reset; // [RULE_14]
    end

    // ============================================================
    // mask: arguments gather in pend, land on execute
    always_comb begin
        arg_bad = cmd.set_mask && (cmd.arg > `MASK_ARG_MAX); // [RULE_02]
        next_pend = pend;
        next_pend_clr = pend_clr;
        next_mask = event_enable_mask; // [RULE_05]
        if (cmd.set_mask && !arg_bad) begin
            if (cmd.arg == 10'h000) begin
                next_pend = 8'h00; // [RULE_06]
                next_pend_clr = 1'b1;
            end else begin
                next_pend = pend | cmd.arg[7:0]; // [RULE_04]
            end
        end
        if (cmd.execute) begin
            // deferred: nothing reaches the mask before execute
            next_mask = next_pend_clr ? next_pend
                : (event_enable_mask | next_pend); // [RULE_01]
            next_pend = 8'h00;
            next_pend_clr = 1'b0;
        end
        if (cmd.power_on_reset) begin
            next_mask = `MASK_RESET; // [RULE_05]
            next_pend = 8'h00;
            next_pend_clr = 1'b0;
        end
    end

    // ============================================================
    // flags: set wins over the clear of a status read
    always_comb begin
        next_flags = (cmd.status_read ? 8'h00 : event_status_flags)
                     | sets; // [RULE_17]
        next_status_data = cmd.status_read ? event_status_flags
                                           : status_data;
        next_status_valid = cmd.status_read;
        // computed from next values so summary never lags a flag
        next_summary = |(next_flags & next_mask); // [RULE_03]
        next_srq = next_summary && srq_event_enable; // [RULE_16]
    end

    // registers, frozen while ce is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_enable_mask <= `MASK_RESET;
            pend <= 8'h00;
            pend_clr <= 1'b0;
            event_status_flags <= `FLAGS_RESET; // [RULE_14]
            event_summary_bit <= 1'b0;
            serial_poll_status <= 8'h00;
            service_request <= 1'b0;
            status_data <= 8'h00;
            status_valid <= 1'b0;
        end else if (ce) begin
            event_enable_mask <= next_mask;
            pend <= next_pend;
            pend_clr <= next_pend_clr;
            event_status_flags <= next_flags;
            event_summary_bit <= next_summary;
            serial_poll_status <= 8'(next_summary) << `SPS_SUMMARY_POS;
            service_request <= next_srq;
            status_data <= next_status_data;
            status_valid <= next_status_valid;
        end
    end

    // ============================================================
    // query reply uses the live mask, not pending arguments
    mask_reply_formatter u_reply (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(cmd.query), // [RULE_15]
        .value(event_enable_mask),
        .out_ready(reply_ready),
        .out_valid(reply_valid),
        .out_char(reply_char),
        .busy(reply_busy)
    );

    // ============================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_deferred;
        ce && !cmd.execute && !cmd.power_on_reset
            |=> event_enable_mask == $past(event_enable_mask);
    endproperty
    a_deferred: assert property (p_deferred) // [RULE_01] [RULE_05]
        else $error("mask changed without execute");

    property p_or_accum;
        ce && cmd.execute && !pend_clr && !cmd.set_mask
            && !cmd.power_on_reset
            |=> event_enable_mask ==
                ($past(event_enable_mask) | $past(pend));
    endproperty
    a_or_accum: assert property (p_or_accum) // [RULE_04]
        else $error("mask did not accumulate");

    property p_zero_clear;
        ce && cmd.set_mask && cmd.arg == 10'h000 && cmd.execute
            && !cmd.power_on_reset
            |=> event_enable_mask == 8'h00;
    endproperty
    a_zero_clear: assert property (p_zero_clear) // [RULE_06]
        else $error("zero argument did not clear mask");

    property p_range;
        ce && cmd.set_mask && cmd.arg > 10'h0FF && !cmd.execute
            && !cmd.power_on_reset
            |=> event_status_flags[4] && pend == $past(pend);
    endproperty
    a_range: assert property (p_range) // [RULE_02] [RULE_11]
        else $error("out of range argument accepted");

    property p_summary;
        event_summary_bit == |(event_status_flags & event_enable_mask);
    endproperty
    a_summary: assert property (p_summary) // [RULE_03]
        else $error("summary bit disagrees with flags and mask");

    property p_latch;
        ce && !cmd.status_read
            |=> ($past(event_status_flags) & ~event_status_flags) == 8'h00;
    endproperty
    a_latch: assert property (p_latch) // [RULE_17]
        else $error("flag dropped without a read");

    property p_event_set;
        ce && acq_complete |=> event_status_flags[0];
    endproperty
    a_event_set: assert property (p_event_set) // [RULE_07]
        else $error("acquisition complete not latched");

    property p_por;
        ce && cmd.power_on_reset
            |=> event_status_flags[7] && event_enable_mask == 8'h00;
    endproperty
    a_por: assert property (p_por) // [RULE_14]
        else $error("power-on reset command mishandled");

    property p_srq;
        ce |=> service_request == (event_summary_bit
                                   && $past(srq_event_enable));
    endproperty
    a_srq: assert property (p_srq) // [RULE_16]
        else $error("service request wrong");

    property p_query;
        ce && cmd.query && !reply_busy
            |=> reply_valid && reply_char == `REPLY_LETTER;
    endproperty
    a_query: assert property (p_query) // [RULE_15]
        else $error("query reply did not start with letter");

    c_accum: cover property (ce && cmd.execute && pend == 8'h03);
    c_summary: cover property (!event_summary_bit ##1 event_summary_bit);
    c_set_vs_read: cover property (ce && cmd.status_read && |sets);

endmodule // event_status_enable_logic

// ===== event_status_enable_logic_test.sv
// Purpose: self-checking bench for the event status and enable logic
// Assumes: commands as decoded strobes, reply sink in its own model
// Notes: reply bytes and status reads are checked from queues
`timescale 1ns/10ps
`include "event_status_map.svh"

module event_status_enable_logic_test;
    logic clk, rst, ce, srq_event_enable, stall, reply_ready;
    event_status_pkg::cmd_t cmd;
    logic [6:0] ev;
    logic [7:0] event_enable_mask, event_status_flags, serial_poll_status;
    logic [7:0] status_data, reply_char, exp_mask, exp_flags, a, b;
    logic event_summary_bit, service_request, status_valid;
    logic reply_valid, reply_busy;
    logic [7:0] rq[$];
    logic [7:0] sq[$];
    int n_errors, cmp_count, cycles, n;
    integer seed;

    event_status_enable_logic dut (.clk(clk), .rst(rst), .ce(ce),
        .cmd(cmd), .acq_complete(ev[0]), .stop_event(ev[1]),
        .query_error(ev[2]), .param_conflict(ev[3]),
        .invalid_option_error(ev[4]), .invalid_command_error(ev[5]),
        .buffer_threshold(ev[6]), .srq_event_enable(srq_event_enable),
        .reply_ready(reply_ready), .event_enable_mask(event_enable_mask),
        .event_status_flags(event_status_flags),
        .event_summary_bit(event_summary_bit),
        .serial_poll_status(serial_poll_status),
        .service_request(service_request), .status_data(status_data),
        .status_valid(status_valid), .reply_valid(reply_valid),
        .reply_char(reply_char), .reply_busy(reply_busy));

    reply_sink_model host (.clk(clk), .rst(rst), .stall(stall),
        .reply_valid(reply_valid), .reply_ready(reply_ready));

    // =========================================================
    // compare tasks and verdict
    task automatic chk_byte(input string what, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_bit(input string what, input logic e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic give_verdict;
        if (rq.size() != 0 || sq.size() != 0) n_errors++;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // =========================================================
    // drivers
    // strobes last one cycle; an idle cycle separates two sends
    task automatic send(input logic s, x, q, p, r, input logic [9:0] v);
        @(posedge clk);
        cmd <= '{s, x, q, p, r, v};
        @(posedge clk);
        cmd <= '0;
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic check_state;
        logic sum;
        sum = |(exp_flags & exp_mask);
        chk_byte("mask", exp_mask, event_enable_mask);
        chk_byte("flags", exp_flags, event_status_flags);
        chk_bit("summary", sum, event_summary_bit);
        chk_byte("sps", 8'(sum) << `SPS_SUMMARY_POS,
                 serial_poll_status);
        chk_bit("srq", sum & srq_event_enable, service_request);
    endtask

    // notes the four reply characters, then waits for the reply to end
    task automatic do_query;
        rq.push_back(`REPLY_LETTER);
        rq.push_back(`ASCII_ZERO + exp_mask / 8'h64);
        rq.push_back(`ASCII_ZERO + (exp_mask / 8'h0A) % 8'h0A);
        rq.push_back(`ASCII_ZERO + exp_mask % 8'h0A);
        send(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 10'h000);
        repeat (2) @(posedge clk);
        n = 0;
        while (reply_busy !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic read_status;
        sq.push_back(exp_flags);
        send(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 10'h000);
        exp_flags = 8'h00;
    endtask

    // clear-then-load, so the old mask cannot leak into the new one
    task automatic set_mask_to(input logic [7:0] w);
        send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 10'h000);
        send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, {2'b00, w});
        send(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 10'h000);
        exp_mask = w;
    endtask

    task automatic pulse_ev(input int i);
        @(posedge clk);
        ev <= 7'(1 << i);
        @(posedge clk);
        ev <= '0;
        exp_flags[i] = 1'b1;
    endtask

    // =========================================================
    // clock, output watcher and hang limit
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (!rst && reply_valid === 1'b1 && reply_ready === 1'b1)
            chk_byte("reply_char", rq.size() ? rq.pop_front() : 8'hXX,
                     reply_char);
        if (!rst && status_valid === 1'b1)
            chk_byte("status_data", sq.size() ? sq.pop_front() : 8'hXX,
                     status_data);
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            $display("timeout after %0d cycles", cycles);
            give_verdict();
        end
    end

    // =========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        cmd = '0;
        ev = '0;
        srq_event_enable = 1'b0;
        stall = 1'b0;
        seed = 32'h7849;
        exp_mask = `MASK_RESET;
        exp_flags = `FLAGS_RESET;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        check_state();
        $display("test reset done");
        // separate commands accumulate, nothing moves before execute
        send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 10'h001);
        send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 10'h002);
        settle();
        check_state();
        send(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 10'h000);
        exp_mask = 8'h03;
        settle();
        check_state();
        stall = 1'b1;
        do_query();
        send(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 10'h005);
        exp_mask = 8'h07;
        settle();
        check_state();
        send(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 10'h000);
        exp_mask = 8'h00;
        settle();
        check_state();
        do_query();
        stall <= 1'b0;
        $display("test accumulate done");
        // argument above 255 is refused and flagged, execute finds nothing
        send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 10'h12C);
        send(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 10'h000);
        exp_flags[`FLAG_EXEC_ERR] = 1'b1;
        settle();
        check_state();
        @(posedge clk);
        ce <= 1'b0;
        send(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 10'h009);
        @(posedge clk);
        ce <= 1'b1;
        settle();
        check_state();
        $display("test refusal done");
        // flags 0 to 6 alone: a disabled neighbour first, then the enabled one
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            srq_event_enable <= i[0];
            read_status();
            set_mask_to(8'(1 << i));
            pulse_ev((i + 1) % 7);
            settle();
            check_state();
            pulse_ev(i);
            repeat (6) @(posedge clk);
            #1;
            check_state();
            check_state();
        end
        $display("test flags done");
        // random masks through clear and load, read back as digits
        stall <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            a = 8'($random(seed));
            b = 8'($random(seed));
            send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 10'h000);
            send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, {2'b00, a});
            send(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, {2'b00, b});
            // a zero last argument clears pending, so the mask empties
            exp_mask = (b == 8'h00) ? 8'h00 : (a | b);
            do_query();
        end
        $display("test random done");
        // mask held while idle, then power-on reset beats execute
        repeat (20) @(posedge clk);
        #1;
        check_state();
        send(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 10'd5);
        exp_mask = 8'h00;
        exp_flags[`FLAG_POWER_ON] = 1'b1;
        settle();
        check_state();
        do_query();
        read_status();
        settle();
        $display("test power-on done");
        give_verdict();
    end
endmodule // event_status_enable_logic_test

// ===== event_status_map.svh
// Purpose: constants for the event status and enable logic
// Assumes: one clock, commands already parsed into strobes
// Notes: bit positions follow the decimal weights 1 to 128
//
// Summary of operation
// [RULE_01] mask set command applies at execute
// [RULE_02] mask argument limited to 000 through 255
// [RULE_03] summary bit needs flag and enable together
// [RULE_04] separate mask commands OR into the mask
// [RULE_05] mask holds until clear or power-on reset
// [RULE_06] argument zero clears the whole mask
// [RULE_07] weight 1 enables acquisition complete flag
// [RULE_08] weight 2 enables stop event flag
// [RULE_09] weight 4 is query error flag
// [RULE_10] weight 8 is parameter conflict flag
// [RULE_11] weight 16 is invalid option error flag
// [RULE_12] weight 32 is invalid command error flag
// [RULE_13] weight 64 is buffer 75 percent flag
// [RULE_14] weight 128 is power-on flag
// [RULE_15] mask query returns letter and three digits
// [RULE_16] enabled summary raises service request
// [RULE_17] flags stay latched until read or reset
`ifndef EVENT_STATUS_MAP_SVH
`define EVENT_STATUS_MAP_SVH

// ============================================================
// flag positions
`define FLAG_ACQ_DONE 0
`define FLAG_STOP_EVENT 1
`define FLAG_QUERY_ERR 2
`define FLAG_CONFLICT_ERR 3
`define FLAG_EXEC_ERR 4
`define FLAG_CMD_ERR 5
`define FLAG_BUF_THRESH 6
`define FLAG_POWER_ON 7

// ============================================================
// reset values and limits
`define MASK_RESET 8'h00
`define FLAGS_RESET 8'h80
`define FLAGS_POWER_ON 8'h80
`define MASK_ARG_MAX 10'h0FF
`define SPS_SUMMARY_POS 5

// ============================================================
// reply characters
`define REPLY_LETTER 8'h4E
`define ASCII_ZERO 8'h30

`endif

// ===== event_status_pkg.sv
// Purpose: shared types for the event status and enable logic
// Assumes: nothing beyond the map header
// Notes: command strobes travel together as one struct
package event_status_pkg;

    // one-cycle command strobes from the command parser
    typedef struct packed {
        logic set_mask;       // mask argument received
        logic execute;        // execute terminator processed
        logic query;          // mask query received
        logic power_on_reset; // power-on reset command
        logic status_read;    // host reads the status flags
        logic [9:0] arg;      // decimal mask argument as binary
    } cmd_t;

    // reply formatter states
    typedef enum logic [2:0] {
        FMT_IDLE,
        FMT_LETTER,
        FMT_HUNDREDS,
        FMT_TENS,
        FMT_UNITS
    } fmt_state_t;

endpackage

// ===== mask_reply_formatter.sv
// Purpose: turns an 8-bit value into letter plus three digits
// Assumes: sink takes one character per cycle with ready
// Notes: a start while busy is ignored
`timescale 1ns/10ps
`include "event_status_map.svh"

module mask_reply_formatter (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic [7:0] value,
    input wire logic out_ready,
    output logic out_valid,
    output logic [7:0] out_char,
    output logic busy
);

    event_status_pkg::fmt_state_t state, next_state;
    logic [7:0] held, next_held;
    logic [7:0] next_char;
    logic next_valid;

    // ascii digit of one decimal place, place weight 100, 10 or 1
    function automatic logic [7:0] digit(input logic [7:0] v,
                                         input logic [7:0] w);
        logic [7:0] d;
        d = (v / w) % 8'h0A;
        return `ASCII_ZERO + d;
    endfunction

    // ============================================================
    // sequencer: character advances only when the sink took it
    always_comb begin
        next_state = state;
        next_held = held;
        next_char = out_char;
        next_valid = out_valid;
        case (state)
            event_status_pkg::FMT_IDLE: begin
                if (start) begin
                    next_held = value; // snapshot, later changes ignored
                    next_char = `REPLY_LETTER;
                    next_valid = 1'b1;
                    next_state = event_status_pkg::FMT_LETTER;
                end
            end
            event_status_pkg::FMT_LETTER: begin
                if (out_ready) begin
                    next_char = digit(held, 8'h64);
                    next_state = event_status_pkg::FMT_HUNDREDS;
                end
            end
            event_status_pkg::FMT_HUNDREDS: begin
                if (out_ready) begin
                    next_char = digit(held, 8'h0A);
                    next_state = event_status_pkg::FMT_TENS;
                end
            end
            event_status_pkg::FMT_TENS: begin
                if (out_ready) begin
                    next_char = digit(held, 8'h01);
                    next_state = event_status_pkg::FMT_UNITS;
                end
            end
            event_status_pkg::FMT_UNITS: begin
                if (out_ready) begin
                    next_valid = 1'b0;
                    next_char = 8'h00;
                    next_state = event_status_pkg::FMT_IDLE;
                end
            end
            default: begin
                next_state = event_status_pkg::FMT_IDLE;
                next_valid = 1'b0;
            end
        endcase
    end

    // registers, frozen while ce is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= event_status_pkg::FMT_IDLE;
            held <= 8'h00;
            out_char <= 8'h00;
            out_valid <= 1'b0;
            busy <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            held <= next_held;
            out_char <= next_char;
            out_valid <= next_valid;
            busy <= next_state != event_status_pkg::FMT_IDLE;
        end
    end

endmodule // mask_reply_formatter

// ===== reply_sink_model.sv
// Purpose: host-side sink for reply characters, prompt or stalling
// Assumes: one clock, reply bytes offered with valid and taken on ready
// Notes: stall mode drops ready on pseudo-random cycles
`timescale 1ns/10ps

module reply_sink_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic reply_valid,
    output logic reply_ready
);
    integer seed = 32'h7849;

    // =========================================================
    // ready generation
    // a slow host leaves characters standing for several cycles
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reply_ready <= 1'b0;
        end else if (!stall) begin
            reply_ready <= 1'b1; // prompt host
        end else begin
            reply_ready <= 1'($random(seed)) & reply_valid;
        end
    end
endmodule // reply_sink_model
